// ### logic/p0i_pkg.sv
package p0i_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int BYTE_W     = 8;
  localparam int KIND_W     = 2;
  localparam int WORD_W     = BYTE_W + KIND_W;
  localparam int FIFO_DEPTH = 8;
  localparam int DIV_W      = 8;

  // ****************************************
  // strap and loader mode codes
  // ****************************************
  localparam logic [1:0] CODE_MII_MAC  = 2'h0;
  localparam logic [1:0] CODE_MII_PHY  = 2'h1;
  localparam logic [1:0] CODE_RMII_PHY = 2'h2;

  // ****************************************
  // stream word kinds
  // ****************************************
  localparam logic [1:0] KIND_DATA     = 2'h0;
  localparam logic [1:0] KIND_END_OK   = 2'h1;
  localparam logic [1:0] KIND_END_DROP = 2'h2;

  // ****************************************
  // assembly slots
  // ****************************************
  localparam logic [2:0] SLOT_FIRST     = 3'h0;
  localparam logic [2:0] MII_LAST_SLOT  = 3'h1;
  localparam logic [2:0] RMII_LAST_SLOT = 3'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int MCLK_PERIOD_NS  = 25;
  localparam int REF_HALF_NS     = 25;
  localparam int REF_HALF_RAW    = REF_HALF_NS / MCLK_PERIOD_NS;
  localparam int REF_HALF_CYCLES = (REF_HALF_RAW < 1) ? 1 : REF_HALF_RAW;

  // ****************************************
  // port modes
  // ****************************************
  typedef enum logic [1:0] {
    P0I_MII_MAC,
    P0I_MII_PHY,
    P0I_RMII_PHY
  } p0i_mode_e;

  localparam p0i_mode_e RST_MODE = P0I_MII_MAC;

  // map a strap or loader code onto a mode
  function automatic p0i_mode_e p0i_decode_mode(input logic [1:0] code);
    case (code)
      CODE_MII_PHY:  return P0I_MII_PHY;
      CODE_RMII_PHY: return P0I_RMII_PHY;
      default:       return P0I_MII_MAC;
    endcase
  endfunction

endpackage

// ### logic/p0i_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
// valid/ready word stream from the framer into the fifo and from the fifo out to the consumer
interface p0i_stream_if #(
  parameter int W = p0i_pkg::WORD_W
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### logic/p0i_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module p0i_fifo #(
  parameter int W     = p0i_pkg::WORD_W,
  parameter int DEPTH = p0i_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic   mclk,
  input wire logic   rst,
  input wire logic   ce,
  // fill side
  p0i_stream_if.snk  wr,
  // drain side
  p0i_stream_if.src  rd
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } p0i_fifo_s;

  p0i_fifo_s s_q;
  p0i_fifo_s s_d;
  logic      wr_ok;
  logic      rd_ok;

  // wrap a pointer at the last entry
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // honest full and empty from the fill count
  assign wr.ready = (s_q.cnt != (AW + 1)'(DEPTH));
  assign rd.valid = (s_q.cnt != '0);
  assign rd.data  = s_q.mem[s_q.rp];
  assign wr_ok    = wr.valid && wr.ready;
  assign rd_ok    = rd.valid && rd.ready;

  // pointer and count update
  always_comb begin
    s_d = s_q;
    if (wr_ok) begin
      s_d.mem[s_q.wp] = wr.data;
      s_d.wp          = next_ptr(s_q.wp);
    end
    if (rd_ok) begin
      s_d.rp = next_ptr(s_q.rp);
    end
    case ({wr_ok, rd_ok})
      2'b10:   s_d.cnt = (AW + 1)'(s_q.cnt + 1'b1);
      2'b01:   s_d.cnt = (AW + 1)'(s_q.cnt - 1'b1);
      default: s_d.cnt = s_q.cnt;
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  fill_bound_a: assert property (@(posedge mclk) disable iff (rst)
    s_q.cnt <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");

  full_stall_a: assert property (@(posedge mclk) disable iff (rst)
    ce && !wr.ready && !rd_ok |=> !wr.ready)
    else $error("full fifo freed without a read");

endmodule
`default_nettype wire

// ### logic/p0i_ingress.sv
`timescale 1ns/1ps
`default_nettype none
module p0i_ingress #(
  parameter int DEPTH    = p0i_pkg::FIFO_DEPTH,
  parameter int REF_HALF = p0i_pkg::REF_HALF_CYCLES
) (
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       external_reset_n,
  // straps and loader
  input  wire logic [1:0] strap_mode,
  input  wire logic       eeprom_cfg_valid,
  input  wire logic [1:0] eeprom_cfg_mode,
  // control
  input  wire logic       vphy_isolate_bit,
  // port 0 input pins
  input  wire logic       port0_in_data_bit3,
  input  wire logic       port0_in_data_bit2,
  input  wire logic       port0_in_data_bit1,
  input  wire logic       port0_in_data_bit0,
  input  wire logic       port0_in_valid,
  input  wire logic       port0_in_error,
  // reference clock pin
  input  wire logic       port0_in_ref_clock_in,
  output logic            port0_in_ref_clock_out,
  output logic            port0_in_ref_clock_oe,
  // pad controls
  output logic            port0_in_buf_en,
  output logic            port0_in_pulldown_en,
  // frame stream out
  output logic            frm_valid,
  input  wire logic       frm_ready,
  output logic [7:0]      frm_data,
  output logic [1:0]      frm_kind,
  // status
  output logic [1:0]      cfg_mode,
  output logic            cfg_captured,
  output logic            rx_error_pulse,
  output logic            tx_abort_pulse
);

  // ****************************************
  // types and state
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_CLOSE,
    ST_SKIP
  } p0i_fsm_e;

  typedef struct packed {
    logic                        cap_pend;
    logic                        captured;
    p0i_pkg::p0i_mode_e          mode;
    logic                        ref_prev;
    logic [p0i_pkg::DIV_W-1:0]   div_cnt;
    logic                        ref_out;
    p0i_fsm_e                    st;
    logic [p0i_pkg::BYTE_W-1:0]  shreg;
    logic [2:0]                  slot;
    logic                        err_seen;
    logic [p0i_pkg::KIND_W-1:0]  end_kind;
    logic                        rx_err_p;
    logic                        tx_abort_p;
  } p0i_state_s;

  // reset image: capture pending, idle, end kind ok, everything else cleared
  localparam p0i_state_s RST_S = '{cap_pend: 1'b1, mode: p0i_pkg::RST_MODE, st: ST_IDLE,
                                   slot: p0i_pkg::SLOT_FIRST, end_kind: p0i_pkg::KIND_END_OK,
                                   default: '0};
  localparam logic [p0i_pkg::DIV_W-1:0] DIV_LAST = p0i_pkg::DIV_W'(REF_HALF - 1);

  p0i_state_s s_q;
  p0i_state_s s_d;

  // ****************************************
  // pad gating
  // ****************************************
  logic       iso;
  logic [3:0] din;
  logic       dv;
  logic       er;
  logic       smp;
  logic       take;
  logic       push;
  logic [p0i_pkg::WORD_W-1:0] push_word;
  logic       push_ready;
  logic [p0i_pkg::WORD_W-1:0] out_word;
  assign iso = vphy_isolate_bit && (s_q.mode != p0i_pkg::P0I_MII_MAC);
  assign port0_in_buf_en      = !iso;
  assign port0_in_pulldown_en = !iso;
  // gated pin levels, nibble with bit 3 on top
  always_comb begin
    din = 4'h0;
    dv  = 1'b0;
    er  = 1'b0;
    if (!iso) begin
      din = {port0_in_data_bit3, port0_in_data_bit2, port0_in_data_bit1, port0_in_data_bit0};
      dv  = port0_in_valid;
      er  = (s_q.mode == p0i_pkg::P0I_RMII_PHY) ? 1'b0 : port0_in_error;
    end
  end

  // ****************************************
  // sample strobe per mode
  // ****************************************
  always_comb begin
    case (s_q.mode)
      p0i_pkg::P0I_MII_MAC: smp = port0_in_ref_clock_in && !s_q.ref_prev;
      p0i_pkg::P0I_MII_PHY: smp = (s_q.div_cnt == DIV_LAST) && !s_q.ref_out;
      default:              smp = 1'b1;
    endcase
  end

  assign take = smp && dv && ((s_q.st == ST_IDLE) || (s_q.st == ST_RECV));
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [p0i_pkg::BYTE_W-1:0] nxt;
    logic [2:0]                 slot_now;
    logic [2:0]                 slot_last;
    nxt        = s_q.shreg;
    slot_now   = s_q.slot;
    slot_last  = p0i_pkg::MII_LAST_SLOT;
    s_d        = s_q;
    push       = 1'b0;
    push_word  = '0;
    s_d.rx_err_p   = 1'b0;
    s_d.tx_abort_p = 1'b0;
    s_d.ref_prev   = port0_in_ref_clock_in;
    if (!external_reset_n) begin
      s_d = RST_S;
    end else begin
      if (s_q.cap_pend) begin
        s_d.mode     = p0i_pkg::p0i_decode_mode(strap_mode);
        s_d.captured = 1'b1;
        s_d.cap_pend = 1'b0;
      end else if (eeprom_cfg_valid && s_q.captured) begin
        s_d.mode = p0i_pkg::p0i_decode_mode(eeprom_cfg_mode);
      end
      if (s_q.mode == p0i_pkg::P0I_MII_PHY) begin
        if (s_q.div_cnt == DIV_LAST) begin
          s_d.div_cnt = '0;
          s_d.ref_out = !s_q.ref_out;
        end else begin
          s_d.div_cnt = p0i_pkg::DIV_W'(s_q.div_cnt + 1'b1);
        end
      end else begin
        s_d.div_cnt = '0;
        s_d.ref_out = 1'b0;
      end
      // frame sequencing
      case (s_q.st)
        ST_IDLE: begin
          if (take) begin
            s_d.st       = ST_RECV;
            s_d.err_seen = 1'b0;
            slot_now     = p0i_pkg::SLOT_FIRST;
          end
        end
        ST_RECV: begin
          if (smp && !dv) begin
            // partial byte or error leaves the frame unfit
            s_d.end_kind = ((s_q.slot != p0i_pkg::SLOT_FIRST) || s_q.err_seen) ?
                           p0i_pkg::KIND_END_DROP : p0i_pkg::KIND_END_OK;
            s_d.st       = ST_CLOSE;
          end
        end
        ST_CLOSE: begin
          push      = 1'b1;
          push_word = {s_q.end_kind, 8'h00};
          if (push_ready) begin
            s_d.st = ST_SKIP;
          end
        end
        ST_SKIP: begin
          if (smp && !dv) begin
            s_d.st = ST_IDLE;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
      // nibble or dibit assembly
      if (take) begin
        if (er) begin
          if (s_q.mode == p0i_pkg::P0I_MII_MAC) begin
            s_d.rx_err_p = 1'b1;
          end else begin
            s_d.tx_abort_p = 1'b1;
          end
          s_d.err_seen = 1'b1;
          s_d.end_kind = p0i_pkg::KIND_END_DROP;
          s_d.st       = ST_CLOSE;
        end else begin
          if (s_q.mode == p0i_pkg::P0I_RMII_PHY) begin
            // dibit from bits 1 and 0
            nxt       = {din[1:0], s_q.shreg[7:2]};
            slot_last = p0i_pkg::RMII_LAST_SLOT;
          end else begin
            nxt = {din, s_q.shreg[7:4]};
          end
          s_d.shreg = nxt;
          if (slot_now == slot_last) begin
            s_d.slot  = p0i_pkg::SLOT_FIRST;
            push      = 1'b1;
            push_word = {p0i_pkg::KIND_DATA, nxt};
            if (!push_ready) begin
              // overflow spoils the frame
              s_d.end_kind = p0i_pkg::KIND_END_DROP;
              s_d.st       = ST_CLOSE;
            end
          end else begin
            s_d.slot = 3'(slot_now + 1'b1);
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= RST_S;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  // ****************************************
  // buffer and outputs
  // ****************************************
  p0i_stream_if #(.W(p0i_pkg::WORD_W)) fill_if ();
  p0i_stream_if #(.W(p0i_pkg::WORD_W)) drain_if ();
  assign fill_if.valid  = push;
  assign fill_if.data   = push_word;
  assign push_ready     = fill_if.ready;
  assign frm_valid      = drain_if.valid;
  assign drain_if.ready = frm_ready;
  assign out_word       = drain_if.data;

  // word buffer between framer and consumer
  p0i_fifo #(.W(p0i_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .mclk (mclk), .rst (rst), .ce (ce), .wr (fill_if), .rd (drain_if)
  );

  // status and pin drive
  assign frm_data               = out_word[p0i_pkg::BYTE_W-1:0];
  assign frm_kind               = out_word[p0i_pkg::WORD_W-1:p0i_pkg::BYTE_W];
  assign cfg_mode               = s_q.mode;
  assign cfg_captured           = s_q.captured;
  assign rx_error_pulse         = s_q.rx_err_p;
  assign tx_abort_pulse         = s_q.tx_abort_p;
  assign port0_in_ref_clock_out = s_q.ref_out;
  // drive clock only in mii phy mode
  assign port0_in_ref_clock_oe  = (s_q.mode == p0i_pkg::P0I_MII_PHY) && !vphy_isolate_bit;
  // ****************************************
  // checks
  // ****************************************
  strap_capture_a: assert property (@(posedge mclk) disable iff (rst)
    ce && external_reset_n && s_q.cap_pend |=>
      s_q.captured && (s_q.mode == p0i_pkg::p0i_decode_mode($past(strap_mode))))
    else $error("straps not captured after reset release");
  loader_override_a: assert property (@(posedge mclk) disable iff (rst)
    ce && external_reset_n && !s_q.cap_pend && s_q.captured && eeprom_cfg_valid |=>
      s_q.mode == p0i_pkg::p0i_decode_mode($past(eeprom_cfg_mode)))
    else $error("loader value did not replace mode");
  mac_nibble_a: assert property (@(posedge mclk) disable iff (rst)
    ce && push && (push_word[9:8] == p0i_pkg::KIND_DATA) &&
      (s_q.mode == p0i_pkg::P0I_MII_MAC) |->
      push_word[7:4] == {port0_in_data_bit3, port0_in_data_bit2,
                         port0_in_data_bit1, port0_in_data_bit0})
    else $error("mac nibble order wrong");
  phy_nibble_a: assert property (@(posedge mclk) disable iff (rst)
    ce && push && (push_word[9:8] == p0i_pkg::KIND_DATA) &&
      (s_q.mode == p0i_pkg::P0I_MII_PHY) |->
      push_word[7:4] == din && !iso)
    else $error("phy nibble wrong");
  rmii_dibit_a: assert property (@(posedge mclk) disable iff (rst)
    ce && push && (push_word[9:8] == p0i_pkg::KIND_DATA) &&
      (s_q.mode == p0i_pkg::P0I_RMII_PHY) |->
      push_word[7:6] == {port0_in_data_bit1, port0_in_data_bit0})
    else $error("rmii dibit wrong");
  rmii_no_error_a: assert property (@(posedge mclk) disable iff (rst)
    ce && external_reset_n && (s_q.mode == p0i_pkg::P0I_RMII_PHY) && port0_in_valid |=>
      !s_q.rx_err_p && !s_q.tx_abort_p)
    else $error("error pin acted in rmii mode");
  isolate_pads_a: assert property (@(posedge mclk) disable iff (rst)
    vphy_isolate_bit && (s_q.mode != p0i_pkg::P0I_MII_MAC) |->
      !port0_in_buf_en && !port0_in_pulldown_en && !port0_in_ref_clock_oe)
    else $error("pads live while isolated");
  mac_valid_a: assert property (@(posedge mclk) disable iff (rst)
    ce && (s_q.st == ST_IDLE) && !port0_in_valid && (s_q.mode == p0i_pkg::P0I_MII_MAC) |->
      !push && !take)
    else $error("data taken without rx_dv");
  phy_valid_a: assert property (@(posedge mclk) disable iff (rst)
    ce && (s_q.mode != p0i_pkg::P0I_MII_MAC) && !dv |-> !take)
    else $error("data taken without tx_en");
  rx_error_a: assert property (@(posedge mclk) disable iff (rst)
    ce && external_reset_n && take && er && (s_q.mode == p0i_pkg::P0I_MII_MAC) |=>
      rx_error_pulse && (s_q.end_kind == p0i_pkg::KIND_END_DROP))
    else $error("rx error not marked");
  tx_abort_a: assert property (@(posedge mclk) disable iff (rst)
    ce && external_reset_n && take && er && (s_q.mode == p0i_pkg::P0I_MII_PHY) |=>
      tx_abort_pulse && (s_q.st == ST_CLOSE))
    else $error("tx error did not abort");
  mac_edge_a: assert property (@(posedge mclk) disable iff (rst)
    take && (s_q.mode == p0i_pkg::P0I_MII_MAC) |->
      port0_in_ref_clock_in && !s_q.ref_prev)
    else $error("mac sample off the clock edge");
  own_clock_a: assert property (@(posedge mclk) disable iff (rst)
    ce && external_reset_n && take && (s_q.mode == p0i_pkg::P0I_MII_PHY) &&
      !eeprom_cfg_valid |=> port0_in_ref_clock_out)
    else $error("phy sample not on own rising edge");
  drop_errored_a: assert property (@(posedge mclk) disable iff (rst)
    push && (push_word[9:8] == p0i_pkg::KIND_END_OK) |-> !s_q.err_seen)
    else $error("errored frame forwarded");

endmodule
`default_nettype wire

// ### tb/p0i_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-end mac or phy on the port 0 pins
// ****************************************
module p0i_far_end (
  // clock
  input  wire logic  mclk,
  // port 0 pins
  output logic [3:0] data,
  output logic       valid,
  output logic       error,
  output logic       ref_clk
);
  // idle lines sit at their pull-down level
  initial begin
    data = 4'h0;
    valid = 1'b0;
    error = 1'b0;
    ref_clk = 1'b0;
  end

  always @(negedge mclk) ref_clk <= ~ref_clk;

  // one frame, each unit held for one strobe period
  task automatic send(input logic [7:0] b[$], input int err_u, input logic rmii);
    int         n;
    logic [3:0] u;
    n = rmii ? 4 : 2;
    for (int i = 0; i < b.size() * n; i++) begin
      if (rmii) u = 4'((b[i / 4] >> (2 * (i % 4))) & 8'h03);
      else u = 4'((b[i / 2] >> (4 * (i % 2))) & 8'h0f);
      // unused upper lines carry junk in rmii
      if (rmii) u[3:2] = ~u[1:0];
      data = u;
      valid = 1'b1;
      error = (i == err_u);
      repeat (rmii ? 1 : 2) @(negedge mclk);
    end
    data = 4'h0;
    valid = 1'b0;
    error = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ### tb/port0_mii_rmii_ingress_pins_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// ingress pin bench
// ****************************************
module port0_mii_rmii_ingress_pins_test;
  logic       mclk;
  logic       rst;
  logic       ce;
  logic       external_reset_n;
  logic [1:0] strap_mode;
  logic       eeprom_cfg_valid;
  logic [1:0] eeprom_cfg_mode;
  logic       vphy_isolate_bit;
  logic [3:0] pin_data;
  logic       pin_valid;
  logic       pin_error;
  logic       ref_far;
  logic       ref_out;
  logic       ref_oe;
  logic       buf_en;
  logic       pd_en;
  logic       frm_valid;
  logic       frm_ready;
  logic [7:0] frm_data;
  logic [1:0] frm_kind;
  logic [1:0] cfg_mode;
  logic       cfg_captured;
  logic       rx_error_pulse;
  logic       tx_abort_pulse;
  logic       seen_rx;
  logic       seen_tx;
  logic [9:0] got[$];
  int         n_fail;
  int         checks;

  p0i_ingress i_p0i_ingress (
    .mclk(mclk), .rst(rst), .ce(ce), .external_reset_n(external_reset_n),
    .strap_mode(strap_mode), .eeprom_cfg_valid(eeprom_cfg_valid),
    .eeprom_cfg_mode(eeprom_cfg_mode), .vphy_isolate_bit(vphy_isolate_bit),
    .port0_in_data_bit3(pin_data[3]), .port0_in_data_bit2(pin_data[2]),
    .port0_in_data_bit1(pin_data[1]), .port0_in_data_bit0(pin_data[0]),
    .port0_in_valid(pin_valid), .port0_in_error(pin_error),
    .port0_in_ref_clock_in(ref_oe ? ref_out : ref_far),
    .port0_in_ref_clock_out(ref_out), .port0_in_ref_clock_oe(ref_oe),
    .port0_in_buf_en(buf_en), .port0_in_pulldown_en(pd_en),
    .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_data(frm_data),
    .frm_kind(frm_kind), .cfg_mode(cfg_mode), .cfg_captured(cfg_captured),
    .rx_error_pulse(rx_error_pulse), .tx_abort_pulse(tx_abort_pulse));

  p0i_far_end i_p0i_far_end (
    .mclk(mclk), .data(pin_data), .valid(pin_valid), .error(pin_error),
    .ref_clk(ref_far));

  // 40 mhz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // collect stream words and error pulses
  always @(posedge mclk) begin
    if (frm_valid === 1'b1 && frm_ready === 1'b1) got.push_back({frm_kind, frm_data});
    if (rx_error_pulse === 1'b1) seen_rx <= 1'b1;
    if (tx_abort_pulse === 1'b1) seen_tx <= 1'b1;
  end

  // status compare
  task automatic cmp(input logic [9:0] g, input logic [9:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // stream word compare, bounded wait
  task automatic cmp_word(input logic [7:0] d, input logic [1:0] k);
    int t;
    t = 0;
    while (got.size() == 0 && t < 200) begin
      @(negedge mclk);
      t++;
    end
    if (got.size() == 0) cmp(10'h3ff, {k, d}, "no word");
    else cmp(got.pop_front(), {k, d}, "word");
  endtask

  // send a frame and compare what comes out
  task automatic frame(input logic [7:0] b[$], input int err_u, input logic rmii,
                       input int n_ok, input logic [1:0] k_end);
    i_p0i_far_end.send(b, err_u, rmii);
    for (int i = 0; i < n_ok; i++) cmp_word(b[i], p0i_pkg::KIND_DATA);
    cmp_word(8'h00, k_end);
  endtask

  // loader write of a mode code
  task automatic set_mode(input logic [1:0] m);
    eeprom_cfg_mode = m;
    eeprom_cfg_valid = 1'b1;
    @(negedge mclk);
    eeprom_cfg_valid = 1'b0;
    repeat (4) @(negedge mclk);
    cmp(10'(cfg_mode), 10'(m), "mode");
  endtask

  // verdict
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial begin
    logic [7:0] fb[$];
    logic       r0;
    rst = 1'b1;
    ce = 1'b1;
    external_reset_n = 1'b1;
    strap_mode = p0i_pkg::CODE_RMII_PHY;
    eeprom_cfg_valid = 1'b0;
    eeprom_cfg_mode = 2'h0;
    vphy_isolate_bit = 1'b0;
    frm_ready = 1'b1;
    seen_rx = 1'b0;
    seen_tx = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (20) @(negedge mclk);
    cmp(10'(cfg_captured), 10'h0, "captured in reset");
    cmp(10'({buf_en, pd_en, ref_oe}), 10'h6, "pads in reset");
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    cmp(10'({cfg_captured, cfg_mode}), 10'h6, "strap rmii");
    strap_mode = p0i_pkg::CODE_MII_PHY;
    external_reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    cmp(10'(cfg_captured), 10'h0, "captured in pin reset");
    external_reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    cmp(10'({cfg_captured, cfg_mode}), 10'h5, "strap mii phy");
    set_mode(p0i_pkg::CODE_MII_MAC);
    vphy_isolate_bit = 1'b1;
    @(negedge mclk);
    cmp(10'({buf_en, pd_en, ref_oe}), 10'h6, "mac pads");
    vphy_isolate_bit = 1'b0;
    frame('{8'h5a, 8'hc3}, -1, 1'b0, 2, p0i_pkg::KIND_END_OK);
    frame('{8'h5a, 8'hc3, 8'h11}, 2, 1'b0, 1, p0i_pkg::KIND_END_DROP);
    cmp(10'(seen_rx), 10'h1, "rx error pulse");
    set_mode(p0i_pkg::CODE_MII_PHY);
    r0 = ref_out;
    @(negedge mclk);
    cmp(10'({ref_oe, r0 ^ ref_out}), 10'h3, "ref drive toggling");
    frame('{8'ha7}, -1, 1'b0, 1, p0i_pkg::KIND_END_OK);
    frame('{8'h3c, 8'h96}, 1, 1'b0, 0, p0i_pkg::KIND_END_DROP);
    cmp(10'(seen_tx), 10'h1, "tx abort pulse");
    vphy_isolate_bit = 1'b1;
    @(negedge mclk);
    cmp(10'({buf_en, pd_en, ref_oe}), 10'h0, "isolated pads");
    i_p0i_far_end.send('{8'h77}, -1, 1'b0);
    cmp(10'(got.size()), 10'h0, "isolated frame");
    vphy_isolate_bit = 1'b0;
    set_mode(p0i_pkg::CODE_RMII_PHY);
    frame('{8'h39, 8'he4}, 3, 1'b1, 2, p0i_pkg::KIND_END_OK);
    // fill the fifo with the consumer stalled, then drain
    for (int i = 0; i < p0i_pkg::FIFO_DEPTH - 1; i++) fb.push_back(8'(i * 37 + 1));
    frm_ready = 1'b0;
    i_p0i_far_end.send(fb, -1, 1'b1);
    cmp(10'({frm_valid, frm_kind}), 10'h4, "head valid while stalled");
    cmp(10'(frm_data), 10'(fb[0]), "head while stalled");
    frm_ready = 1'b1;
    for (int i = 0; i < fb.size(); i++) cmp_word(fb[i], p0i_pkg::KIND_DATA);
    cmp_word(8'h00, p0i_pkg::KIND_END_OK);
    repeat (4) @(negedge mclk);
    cmp(10'({frm_valid, 9'(got.size())}), 10'h0, "drained");
    // loader strobe while frozen, then the spare mode code
    ce = 1'b0;
    eeprom_cfg_mode = p0i_pkg::CODE_MII_PHY;
    eeprom_cfg_valid = 1'b1;
    repeat (2) @(negedge mclk);
    ce = 1'b1;
    eeprom_cfg_valid = 1'b0;
    @(negedge mclk);
    cmp(10'(cfg_mode), 10'(p0i_pkg::CODE_RMII_PHY), "frozen mode");
    eeprom_cfg_mode = 2'h3;
    eeprom_cfg_valid = 1'b1;
    @(negedge mclk);
    eeprom_cfg_valid = 1'b0;
    @(negedge mclk);
    cmp(10'(cfg_mode), 10'(p0i_pkg::CODE_MII_MAC), "spare code");
    end_of_test();
  end
endmodule
`default_nettype wire
